// >>> include/tdp_params.svh
// constants shared by both ends of the transceiver debug port
`ifndef TDP_PARAMS_SVH
`define TDP_PARAMS_SVH
`define LANE_COUNT 2
`define ADDR_W 10
`define DATA_W 16
`define RATE_W 3
`define LOOP_W 3
`define RXBUF_W 3
`define TXBUF_W 2
`define CNT_W 8
`define CFG_DEPTH 1024
`define CFG_LAT 8'h03
`define TX_RST_CYC 8'h10
`define RX_AN_CYC 8'h0c
`define RX_RST_CYC 8'h18
`define PLL_LOCK_CYC 8'h20
`define PULSE_CYC 8'h04
`define RXBUF_OK 3'h0
`define RXBUF_RST 3'h5
`define TXBUF_OK 2'h0
`define TXBUF_RST 2'h2
`define LOOP_RD_ADDR 10'h3ff
`define MGMT_EN 1'b0
`define F1 8
`define F2 16
`define F3 24
`define A_CFG_ADDR 12'h000
`define A_CFG_WDATA 12'h004
`define A_CFG_CTRL 12'h008
`define A_CFG_RDATA 12'h00c
`define A_RST_REQ 12'h010
`define A_RST_REQ2 12'h014
`define A_RATE 12'h018
`define A_LOOP 12'h01c
`define A_STAT 12'h020
`define A_ESCAN 12'h024
`define A_RXBUF 12'h028
`define A_TXBUF 12'h02c
`endif

// >>> include/tdp_pkg.sv
// types shared by both ends of the transceiver debug port
package tdp_pkg;
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_WAIT = 2'b01
  } cfg_state_type;
  typedef enum logic [2:0] {
    LOOP_NONE = 3'b000,
    LOOP_NEAR_CODING = 3'b001,
    LOOP_NEAR_ANALOG = 3'b010,
    LOOP_FAR_ANALOG = 3'b100,
    LOOP_FAR_CODING = 3'b110
  } loop_mode_type;
endpackage : tdp_pkg

// >>> include/debug_port_if.sv
// signals between the debug controller and the transceiver lane_count
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
interface debug_port_if;
  logic [`ADDR_W-1:0] cfg_port_addr;
  logic [`DATA_W-1:0] cfg_port_wdata;
  logic cfg_port_enable;
  logic cfg_port_write_en;
  logic [`DATA_W-1:0] cfg_port_rdata;
  logic cfg_port_ready;
  logic [`LANE_COUNT-1:0] tx_analog_reset_req;
  logic [`LANE_COUNT-1:0] tx_coding_reset_req;
  logic [`LANE_COUNT-1:0] tx_reset_complete;
  logic [`LANE_COUNT-1:0] rx_analog_reset_req;
  logic [`LANE_COUNT-1:0] rx_coding_reset_req;
  logic [`LANE_COUNT-1:0] rx_elastic_buf_reset_req;
  logic [`LANE_COUNT-1:0] rx_analog_reset_complete;
  logic [`LANE_COUNT-1:0] rx_reset_complete;
  logic [`LANE_COUNT*`TXBUF_W-1:0] tx_elastic_buf_state;
  logic [`LANE_COUNT*`RXBUF_W-1:0] rx_elastic_buf_state;
  logic [`LANE_COUNT-1:0] channel_pll_locked;
  logic [`LANE_COUNT*`RATE_W-1:0] rx_line_rate_sel;
  logic [`LANE_COUNT-1:0] eye_scan_trigger_in;
  logic [`LANE_COUNT-1:0] eye_scan_reset_req;
  logic [`LANE_COUNT-1:0] eye_scan_error_flag;
  logic [`LANE_COUNT*`LOOP_W-1:0] lane_loop_select;
  modport device_end (
    input cfg_port_addr, cfg_port_wdata, cfg_port_enable,
    input cfg_port_write_en, tx_analog_reset_req, tx_coding_reset_req,
    input rx_analog_reset_req, rx_coding_reset_req,
    input rx_elastic_buf_reset_req, rx_line_rate_sel,
    input eye_scan_trigger_in, eye_scan_reset_req, lane_loop_select,
    output cfg_port_rdata, cfg_port_ready, tx_reset_complete,
    output rx_analog_reset_complete, rx_reset_complete,
    output tx_elastic_buf_state, rx_elastic_buf_state,
    output channel_pll_locked, eye_scan_error_flag
  );
  modport host_end (
    output cfg_port_addr, cfg_port_wdata, cfg_port_enable,
    output cfg_port_write_en, tx_analog_reset_req, tx_coding_reset_req,
    output rx_analog_reset_req, rx_coding_reset_req,
    output rx_elastic_buf_reset_req, rx_line_rate_sel,
    output eye_scan_trigger_in, eye_scan_reset_req, lane_loop_select,
    input cfg_port_rdata, cfg_port_ready, tx_reset_complete,
    input rx_analog_reset_complete, rx_reset_complete,
    input tx_elastic_buf_state, rx_elastic_buf_state,
    input channel_pll_locked, eye_scan_error_flag
  );
endinterface : debug_port_if
`default_nettype wire

// >>> src/sync2.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : sync2
`default_nettype wire

// >>> src/debug_device.sv
// lane-side end: config space, reset sequencing, status and loopback
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module debug_device (
  input wire logic pclk,
  input wire logic presetn,
  debug_port_if.device_end dp,
  output logic [`LANE_COUNT*`LOOP_W-1:0] lane_loop_mode
);
  localparam int L = `LANE_COUNT;
  localparam int SW = 5 * L + L * `LOOP_W;

  logic [SW-1:0] async_raw;
  logic [SW-1:0] async_s;
  logic [L-1:0] tx_an_s, tx_cd_s, rx_an_s, rx_cd_s, esr_s;
  logic [L*`LOOP_W-1:0] loop_s;
  logic [L-1:0] tx_an_p, tx_cd_p, rx_an_p, rx_cd_p, esr_p, buf_p;
  logic [L*`RATE_W-1:0] rate_p;
  logic [L-1:0] buf_s;

  // lane reset and loop requests pass two flops first; trigger and rate select do not
  assign async_raw = {dp.lane_loop_select, dp.eye_scan_reset_req,
                      dp.rx_coding_reset_req, dp.rx_analog_reset_req,
                      dp.tx_coding_reset_req, dp.tx_analog_reset_req};
  sync2 #(.WIDTH(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(async_raw),
    .sync_out(async_s)
  );
  sync2 #(.WIDTH(L)) u_sync_buf (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(dp.rx_elastic_buf_reset_req),
    .sync_out(buf_s)
  );
  assign tx_an_s = async_s[0 +: L];
  assign tx_cd_s = async_s[L +: L];
  assign rx_an_s = async_s[2*L +: L];
  assign rx_cd_s = async_s[3*L +: L];
  assign esr_s = async_s[4*L +: L];
  assign loop_s = async_s[5*L +: L*`LOOP_W];

  // previous samples for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_an_p <= '0;
      tx_cd_p <= '0;
      rx_an_p <= '0;
      rx_cd_p <= '0;
      esr_p <= '0;
      buf_p <= '0;
      rate_p <= '0;
    end
    else
    begin
      tx_an_p <= tx_an_s;
      tx_cd_p <= tx_cd_s;
      rx_an_p <= rx_an_s;
      rx_cd_p <= rx_cd_s;
      esr_p <= esr_s;
      buf_p <= buf_s;
      rate_p <= dp.rx_line_rate_sel;
    end
  end

  // ---- configuration port ----
  logic [`DATA_W-1:0] cfg_mem [`CFG_DEPTH];
  tdp_pkg::cfg_state_type cfg_state_q;
  logic [`ADDR_W-1:0] cfg_addr_q;
  logic [`DATA_W-1:0] cfg_wdata_q;
  logic cfg_we_q;
  logic [`CNT_W-1:0] cfg_cnt_q;
  logic [`DATA_W-1:0] cfg_rdata_q;
  logic cfg_ready_q;
  logic cfg_start;
  logic cfg_finish;
  logic [`DATA_W-1:0] cfg_read_word;

  assign cfg_start = dp.cfg_port_enable & ~`MGMT_EN;
  assign cfg_finish = (cfg_state_q == tdp_pkg::CFG_WAIT)
                      && (cfg_cnt_q == `CNT_W'(1));
  assign cfg_read_word = (cfg_addr_q == `LOOP_RD_ADDR)
                         ? `DATA_W'(lane_loop_mode)
                         : cfg_mem[cfg_addr_q];

  // one access per enable cycle; enable while busy is ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_state_q <= tdp_pkg::CFG_IDLE;
      cfg_addr_q <= '0;
      cfg_wdata_q <= '0;
      cfg_we_q <= 1'b0;
      cfg_cnt_q <= '0;
      cfg_rdata_q <= '0;
      cfg_ready_q <= 1'b0;
    end
    else
    begin
      cfg_ready_q <= 1'b0;
      case (cfg_state_q)
        tdp_pkg::CFG_IDLE:
        begin
          if (cfg_start)
          begin
            cfg_addr_q <= dp.cfg_port_addr;
            cfg_wdata_q <= dp.cfg_port_wdata;
            cfg_we_q <= dp.cfg_port_write_en;
            cfg_cnt_q <= `CFG_LAT;
            cfg_state_q <= tdp_pkg::CFG_WAIT;
          end
        end
        tdp_pkg::CFG_WAIT:
        begin
          cfg_cnt_q <= cfg_cnt_q - `CNT_W'(1);
          if (cfg_finish)
          begin
            cfg_ready_q <= 1'b1;
            if (!cfg_we_q)
            begin
              cfg_rdata_q <= cfg_read_word;
            end
            cfg_state_q <= tdp_pkg::CFG_IDLE;
          end
        end
        default:
        begin
          cfg_state_q <= tdp_pkg::CFG_IDLE;
        end
      endcase
    end
  end

  // storage written when a write completes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `CFG_DEPTH; i++)
      begin
        cfg_mem[i] <= '0;
      end
    end
    else if (cfg_finish && cfg_we_q)
    begin
      cfg_mem[cfg_addr_q] <= cfg_wdata_q;
    end
  end

  assign dp.cfg_port_rdata = cfg_rdata_q;
  assign dp.cfg_port_ready = cfg_ready_q;

  // ---- per-lane reset sequencing and status ----
  logic [`CNT_W-1:0] tx_cnt_q [L];
  logic [`CNT_W-1:0] an_cnt_q [L];
  logic [`CNT_W-1:0] rx_cnt_q [L];
  logic [`CNT_W-1:0] pll_cnt_q [L];
  logic [L-1:0] tx_done_q, an_done_q, rx_done_q, lock_q, err_q;
  logic [L*`TXBUF_W-1:0] txbuf_q;
  logic [L*`RXBUF_W-1:0] rxbuf_q;
  logic [L*`LOOP_W-1:0] loop_q;

  function automatic logic [`LOOP_W-1:0] loop_decode(
    input logic [`LOOP_W-1:0] code
  );
    case (code)
      tdp_pkg::LOOP_NEAR_CODING,
      tdp_pkg::LOOP_NEAR_ANALOG,
      tdp_pkg::LOOP_FAR_ANALOG,
      tdp_pkg::LOOP_FAR_CODING: loop_decode = code;
      default: loop_decode = tdp_pkg::LOOP_NONE;
    endcase
  endfunction : loop_decode

  genvar g;
  generate
    for (g = 0; g < L; g++)
    begin : g_lane
      logic tx_go, an_go, rx_go, es_go, trig;
      assign tx_go = (tx_an_s[g] & ~tx_an_p[g])
                     | (tx_cd_s[g] & ~tx_cd_p[g]);
      assign an_go = rx_an_s[g] & ~rx_an_p[g];
      assign rx_go = an_go | (rx_cd_s[g] & ~rx_cd_p[g])
                     | (buf_p[g] & ~buf_s[g])
                     | (rate_p[g*`RATE_W +: `RATE_W]
                        != dp.rx_line_rate_sel[g*`RATE_W +: `RATE_W]);
      assign es_go = esr_s[g] & ~esr_p[g];
      assign trig = dp.eye_scan_trigger_in[g];

      // countdowns; a fresh request restarts the count
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tx_cnt_q[g] <= `TX_RST_CYC;
          an_cnt_q[g] <= `RX_AN_CYC;
          rx_cnt_q[g] <= `RX_RST_CYC;
          pll_cnt_q[g] <= `PLL_LOCK_CYC;
        end
        else
        begin
          tx_cnt_q[g] <= tx_go ? `TX_RST_CYC
                         : tx_cnt_q[g] - `CNT_W'(tx_cnt_q[g] != '0);
          an_cnt_q[g] <= an_go ? `RX_AN_CYC
                         : an_cnt_q[g] - `CNT_W'(an_cnt_q[g] != '0);
          rx_cnt_q[g] <= rx_go ? `RX_RST_CYC
                         : rx_cnt_q[g] - `CNT_W'(rx_cnt_q[g] != '0);
          pll_cnt_q[g] <= pll_cnt_q[g] - `CNT_W'(pll_cnt_q[g] != '0);
        end
      end

      // registered lane status
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tx_done_q[g] <= 1'b0;
          an_done_q[g] <= 1'b0;
          rx_done_q[g] <= 1'b0;
          lock_q[g] <= 1'b0;
          err_q[g] <= 1'b0;
          txbuf_q[g*`TXBUF_W +: `TXBUF_W] <= `TXBUF_RST;
          rxbuf_q[g*`RXBUF_W +: `RXBUF_W] <= `RXBUF_RST;
          loop_q[g*`LOOP_W +: `LOOP_W] <= '0;
        end
        else
        begin
          tx_done_q[g] <= ~tx_go & (tx_cnt_q[g] == '0);
          an_done_q[g] <= ~an_go & (an_cnt_q[g] == '0);
          rx_done_q[g] <= ~rx_go & (rx_cnt_q[g] == '0)
                          & (an_cnt_q[g] == '0);
          lock_q[g] <= (pll_cnt_q[g] == '0);
          // trigger on an unsettled receiver is a scan error
          if (trig & ~rx_done_q[g])
          begin
            err_q[g] <= 1'b1;
          end
          else if (es_go)
          begin
            err_q[g] <= 1'b0;
          end
          txbuf_q[g*`TXBUF_W +: `TXBUF_W] <= (tx_cnt_q[g] != '0)
            ? `TXBUF_RST : `TXBUF_OK;
          // rx_go covers the edge before the count reloads, so the
          // buffer never flashes ok between request and countdown
          rxbuf_q[g*`RXBUF_W +: `RXBUF_W] <= (buf_s[g] | rx_go
            | (rx_cnt_q[g] != '0)) ? `RXBUF_RST : `RXBUF_OK;
          loop_q[g*`LOOP_W +: `LOOP_W] <= `MGMT_EN ? '0
            : loop_decode(loop_s[g*`LOOP_W +: `LOOP_W]);
        end
      end
    end
  endgenerate

  // lane vectors, lane n in slice n
  assign dp.tx_reset_complete = tx_done_q;
  assign dp.rx_analog_reset_complete = an_done_q;
  assign dp.rx_reset_complete = rx_done_q;
  assign dp.channel_pll_locked = lock_q;
  assign dp.eye_scan_error_flag = err_q;
  assign dp.tx_elastic_buf_state = txbuf_q;
  assign dp.rx_elastic_buf_state = rxbuf_q;
  assign lane_loop_mode = loop_q;
endmodule : debug_device
`default_nettype wire

// >>> src/debug_host.sv
// controller end: apb registers driving the debug and config ports
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module debug_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  debug_port_if.host_end dp
);
  localparam int L = `LANE_COUNT;
  logic wr, rd_setup, hit;
  tdp_pkg::cfg_state_type st_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [`DATA_W-1:0] wdata_q, rdata_q;
  logic we_q, en_q, done_q;
  logic [6*L-1:0] req_q;
  logic [`CNT_W-1:0] pulse_q;
  logic [L-1:0] trig_q;
  logic [L*`RATE_W-1:0] rate_q;
  logic [L*`LOOP_W-1:0] loop_q;
  logic [31:0] prdata_q, rd_mux;
  logic [3*L-1:0] as_s;
  logic go;

  // apb decode
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign hit = (paddr[1:0] == 2'h0) && (paddr <= `A_TXBUF);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign go = wr && (paddr == `A_CFG_CTRL) && pwdata[0]
              && (st_q == tdp_pkg::CFG_IDLE) && !`MGMT_EN;

  // error flag, pll lock and rx analog done status pass two flops
  sync2 #(.WIDTH(3*L)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({dp.eye_scan_error_flag, dp.channel_pll_locked,
               dp.rx_analog_reset_complete}),
    .sync_out(as_s)
  );

  // read mux, sampled in the setup cycle
  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      `A_CFG_ADDR: rd_mux[`ADDR_W-1:0] = addr_q;
      `A_CFG_WDATA: rd_mux[`DATA_W-1:0] = wdata_q;
      `A_CFG_CTRL: rd_mux[2:0] = {we_q, done_q,
                                   st_q != tdp_pkg::CFG_IDLE};
      `A_CFG_RDATA: rd_mux[`DATA_W-1:0] = rdata_q;
      `A_RST_REQ: rd_mux[L-1:0] = req_q[L-1:0];
      `A_RATE: rd_mux[L*`RATE_W-1:0] = rate_q;
      `A_LOOP: rd_mux[L*`LOOP_W-1:0] = loop_q;
      `A_STAT:
      begin
        rd_mux[L-1:0] = dp.tx_reset_complete;
        rd_mux[`F1 +: L] = as_s[L-1:0];
        rd_mux[`F2 +: L] = dp.rx_reset_complete;
        rd_mux[`F3 +: L] = as_s[L +: L];
      end
      `A_ESCAN: rd_mux[L-1:0] = as_s[2*L +: L];
      `A_RXBUF: rd_mux[L*`RXBUF_W-1:0] = dp.rx_elastic_buf_state;
      `A_TXBUF: rd_mux[L*`TXBUF_W-1:0] = dp.tx_elastic_buf_state;
      default: rd_mux = 32'h0;
    endcase
  end

  // register writes and read capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      we_q <= 1'b0;
      rate_q <= '0;
      loop_q <= '0;
    end
    else
    begin
      if (rd_setup)
      begin
        prdata_q <= rd_mux;
      end
      if (wr && paddr == `A_CFG_ADDR && st_q == tdp_pkg::CFG_IDLE)
      begin
        addr_q <= pwdata[`ADDR_W-1:0];
      end
      if (wr && paddr == `A_CFG_WDATA && st_q == tdp_pkg::CFG_IDLE)
      begin
        wdata_q <= pwdata[`DATA_W-1:0];
      end
      if (go)
      begin
        we_q <= pwdata[1];
      end
      if (wr && paddr == `A_RATE)
      begin
        rate_q <= pwdata[L*`RATE_W-1:0];
      end
      if (wr && paddr == `A_LOOP)
      begin
        loop_q <= pwdata[L*`LOOP_W-1:0];
      end
    end
  end

  // config access: one enable cycle, hold until ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= tdp_pkg::CFG_IDLE;
      en_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      en_q <= go;
      if (go)
      begin
        st_q <= tdp_pkg::CFG_WAIT;
        done_q <= 1'b0;
      end
      else if (st_q == tdp_pkg::CFG_WAIT && dp.cfg_port_ready)
      begin
        st_q <= tdp_pkg::CFG_IDLE;
        done_q <= 1'b1;
        if (!we_q)
        begin
          rdata_q <= dp.cfg_port_rdata;
        end
      end
    end
  end

  // reset request pulses and eye scan trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q <= '0;
      pulse_q <= '0;
      trig_q <= '0;
    end
    else
    begin
      trig_q <= '0;
      if (wr && paddr == `A_RST_REQ)
      begin
        req_q[4*L-1:0] <= {pwdata[`F3 +: L], pwdata[`F2 +: L],
                           pwdata[`F1 +: L], pwdata[L-1:0]};
        pulse_q <= `PULSE_CYC;
      end
      else if (wr && paddr == `A_RST_REQ2)
      begin
        req_q[6*L-1:4*L] <= {pwdata[`F1 +: L], pwdata[L-1:0]};
        trig_q <= pwdata[`F2 +: L];
        pulse_q <= `PULSE_CYC;
      end
      else if (pulse_q == `CNT_W'(1))
      begin
        req_q <= '0;
        pulse_q <= '0;
      end
      else if (pulse_q != '0)
      begin
        pulse_q <= pulse_q - `CNT_W'(1);
      end
    end
  end

  assign prdata = prdata_q;
  assign dp.cfg_port_addr = addr_q;
  assign dp.cfg_port_wdata = wdata_q;
  assign dp.cfg_port_enable = en_q;
  assign dp.cfg_port_write_en = we_q;
  assign dp.tx_analog_reset_req = req_q[0 +: L];
  assign dp.tx_coding_reset_req = req_q[L +: L];
  assign dp.rx_analog_reset_req = req_q[2*L +: L];
  assign dp.rx_coding_reset_req = req_q[3*L +: L];
  assign dp.rx_elastic_buf_reset_req = req_q[4*L +: L];
  assign dp.eye_scan_reset_req = req_q[5*L +: L];
  assign dp.eye_scan_trigger_in = trig_q;
  assign dp.rx_line_rate_sel = rate_q;
  assign dp.lane_loop_select = `MGMT_EN ? '0 : loop_q;
endmodule : debug_host
`default_nettype wire

// >>> verification/transceiver_debug_port_sva.sv
// assertions on the debug port between host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module transceiver_debug_port_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`ADDR_W-1:0] cfg_port_addr,
  input wire logic cfg_port_enable,
  input wire logic cfg_port_write_en,
  input wire logic [`DATA_W-1:0] cfg_port_rdata,
  input wire logic cfg_port_ready,
  input wire logic [`LANE_COUNT-1:0] tx_analog_reset_req,
  input wire logic [`LANE_COUNT-1:0] tx_reset_complete,
  input wire logic [`LANE_COUNT-1:0] rx_reset_complete,
  input wire logic [`LANE_COUNT*`TXBUF_W-1:0] tx_elastic_buf_state,
  input wire logic [`LANE_COUNT-1:0] eye_scan_trigger_in,
  input wire logic [`LANE_COUNT-1:0] eye_scan_reset_req,
  input wire logic [`LANE_COUNT-1:0] eye_scan_error_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // config port handshake
  AST_EN_PULSE: assert property (
    cfg_port_enable |=> !cfg_port_enable)
    else $error("enable held over one cycle");
  // enable seen at edge n is taken there; ready is set three edges on
  // and so is first sampled high at edge n+4
  AST_READY_LAT: assert property (
    cfg_port_enable |-> ##4 cfg_port_ready)
    else $error("ready not four cycles after enable");
  AST_READY_CAUSE: assert property (
    cfg_port_ready |-> $past(cfg_port_enable, 4))
    else $error("ready without an access");
  AST_READY_ONE: assert property (
    cfg_port_ready |=> !cfg_port_ready)
    else $error("ready longer than one cycle");
  AST_RDATA_HOLD: assert property (
    $changed(cfg_port_rdata) |-> cfg_port_ready && !cfg_port_write_en)
    else $error("read data moved outside a read");
  AST_ADDR_STABLE: assert property (
    cfg_port_enable |=>
    ($stable(cfg_port_addr) && $stable(cfg_port_write_en)) [*3])
    else $error("address moved during access");
  // lane reset requests and completion
  AST_REQ_WIDTH: assert property (
    $rose(tx_analog_reset_req[0]) |->
    tx_analog_reset_req[0] [*4] ##1 !tx_analog_reset_req[0])
    else $error("reset request pulse width wrong");
  AST_TX_FALL: assert property (
    $rose(tx_analog_reset_req[0]) |-> ##[2:4] !tx_reset_complete[0])
    else $error("tx done did not drop");
  AST_TX_HOLD: assert property (
    $fell(tx_reset_complete[0]) |=> !tx_reset_complete[0] [*8])
    else $error("tx done back too soon");
  AST_TXBUF_CODE: assert property (
    tx_elastic_buf_state[1:0] inside {`TXBUF_OK, `TXBUF_RST})
    else $error("tx buffer code invalid");
  // eye scan error set and clear
  AST_ERR_SET: assert property (
    eye_scan_trigger_in[0] && !rx_reset_complete[0] |->
    ##[1:4] eye_scan_error_flag[0])
    else $error("trigger did not raise error");
  AST_ERR_CLR: assert property (
    $rose(eye_scan_reset_req[0]) && !eye_scan_trigger_in[0] |->
    ##[2:6] !eye_scan_error_flag[0])
    else $error("eye scan reset did not clear error");
endmodule : transceiver_debug_port_sva
`default_nettype wire

// >>> verification/tb_transceiver_debug_port.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module tb_transceiver_debug_port;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`LANE_COUNT*`LOOP_W-1:0] lane_loop_mode;
  logic [31:0] rv;
  logic er;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  debug_port_if dp ();
  debug_host i_debug_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp(dp));
  debug_device i_debug_device (.pclk(pclk), .presetn(presetn),
    .dp(dp), .lane_loop_mode(lane_loop_mode));
  transceiver_debug_port_sva i_transceiver_debug_port_sva (.pclk(pclk),
    .presetn(presetn), .cfg_port_addr(dp.cfg_port_addr),
    .cfg_port_enable(dp.cfg_port_enable),
    .cfg_port_write_en(dp.cfg_port_write_en),
    .cfg_port_rdata(dp.cfg_port_rdata),
    .cfg_port_ready(dp.cfg_port_ready),
    .tx_analog_reset_req(dp.tx_analog_reset_req),
    .tx_reset_complete(dp.tx_reset_complete),
    .rx_reset_complete(dp.rx_reset_complete),
    .tx_elastic_buf_state(dp.tx_elastic_buf_state),
    .eye_scan_trigger_in(dp.eye_scan_trigger_in),
    .eye_scan_reset_req(dp.eye_scan_reset_req),
    .eye_scan_error_flag(dp.eye_scan_error_flag));
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // cut a hang short
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, result left in rv and er
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // config port access through the control register, polled to done
  task automatic cfg_op(input logic [9:0] a, input logic [15:0] wd,
    input logic we);
    int i;
    apb(1'b1, `A_CFG_ADDR, {22'h0, a});
    apb(1'b1, `A_CFG_WDATA, {16'h0, wd});
    apb(1'b1, `A_CFG_CTRL, {30'h0, we, 1'b1});
    rv = 32'h0;
    for (i = 0; i < 20 && rv[1] !== 1'b1; i++)
      apb(1'b0, `A_CFG_CTRL, 32'h0);
    chk(rv & 32'h2, 32'h2);
  endtask : cfg_op
  function automatic logic [2:0] dec(input logic [2:0] c);
    dec = (c inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}) ? c : 3'h0;
  endfunction : dec
  task automatic t_reset();
    apb(1'b0, `A_RXBUF, 32'h0);
    chk(rv, 32'h2d);
    apb(1'b0, `A_TXBUF, 32'h0);
    chk(rv, 32'ha);
    repeat (60) @(posedge pclk);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rv, 32'h03030303);
    apb(1'b0, `A_RXBUF, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, `A_TXBUF, 32'h0);
    chk(rv, 32'h0);
  endtask : t_reset
  task automatic t_cfg();
    cfg_op(10'h3fe, 16'ha5c3, 1'b1);
    cfg_op(10'h001, 16'h5a3c, 1'b1);
    cfg_op(10'h3fe, 16'h0, 1'b0);
    apb(1'b0, `A_CFG_RDATA, 32'h0);
    chk(rv, 32'ha5c3);
    cfg_op(10'h001, 16'h0, 1'b0);
    apb(1'b0, `A_CFG_RDATA, 32'h0);
    chk(rv, 32'h5a3c);
    apb(1'b1, 12'h100, 32'hffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rv, 32'h0);
  endtask : t_cfg
  task automatic t_loop();
    logic [2:0] c [6];
    logic [5:0] e;
    int i;
    int k;
    c = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    for (i = 0; i < 6; i++)
    begin
      e = {dec(c[(i+1)%6]), dec(c[i])};
      apb(1'b1, `A_LOOP, {26'h0, c[(i+1)%6], c[i]});
      for (k = 0; k < 10 && lane_loop_mode !== e; k++)
        @(posedge pclk);
      chk({26'h0, lane_loop_mode}, {26'h0, e});
    end
    cfg_op(`LOOP_RD_ADDR, 16'h0, 1'b0);
    apb(1'b0, `A_CFG_RDATA, 32'h0);
    chk(rv, {26'h0, e});
  endtask : t_loop
  task automatic t_lane();
    logic [31:0] m [4];
    int k;
    m = '{32'h1, 32'h1, 32'h100, 32'h10000};
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, `A_RST_REQ, 32'h1 << (8 * k));
      repeat (6) @(posedge pclk);
      apb(1'b0, `A_STAT, 32'h0);
      chk(rv & m[k], 32'h0);
      chk(rv & 32'h02020202, 32'h02020202);
      repeat (50) @(posedge pclk);
      apb(1'b0, `A_STAT, 32'h0);
      chk(rv, 32'h03030303);
    end
  endtask : t_lane
  task automatic t_eye();
    apb(1'b1, `A_RATE, 32'h2);
    apb(1'b1, `A_RST_REQ2, 32'h10000);
    repeat (4) @(posedge pclk);
    apb(1'b0, `A_ESCAN, 32'h0);
    chk(rv, 32'h1);
    apb(1'b1, `A_RST_REQ2, 32'h100);
    repeat (8) @(posedge pclk);
    apb(1'b0, `A_ESCAN, 32'h0);
    chk(rv, 32'h0);
    repeat (50) @(posedge pclk);
    apb(1'b1, `A_RST_REQ2, 32'h10000);
    repeat (6) @(posedge pclk);
    apb(1'b0, `A_ESCAN, 32'h0);
    chk(rv, 32'h0);
    // buffer reset on lane 0: starts when the request falls
    apb(1'b1, `A_RST_REQ2, 32'h1);
    repeat (6) @(posedge pclk);
    apb(1'b0, `A_RXBUF, 32'h0);
    chk(rv, 32'h5);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rv, 32'h03020303);
  endtask : t_eye
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cfg();
    t_loop();
    t_lane();
    t_eye();
    print_verdict();
  end
endmodule : tb_transceiver_debug_port
`default_nettype wire
